// >>> common/nsbp_pkg.sv
// shared constants of the shared-memory bus port: device register indices,
// host-side register offsets, field positions, reset values and clock counts.
// assumes a single bus clock for both ends.
package nsbp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int RA_W = 6;
  localparam int RAM_WORDS = 64;
  // device registers, indexed by the register address lines
  localparam logic [5:0] DREG_CMD = 6'h00;
  localparam logic [5:0] DREG_SYS_ADDR = 6'h01;
  localparam logic [5:0] DREG_LOCAL = 6'h02;
  localparam logic [5:0] DREG_ISR = 6'h03;
  localparam logic [5:0] DREG_IMR = 6'h04;
  localparam logic [5:0] DREG_DCR = 6'h05;
  localparam logic [5:0] DREG_XFER = 6'h06;
  localparam logic [5:0] DREG_STATUS = 6'h07;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int DCR_SYNCHRONOUS_BUS_SELECT_BIT = 0;
  localparam logic DCR_SYNCHRONOUS_BUS_SELECT_RST = 1'b0;
  localparam int ISR_W = 3;
  localparam int ISR_DMA_DONE = 0;
  localparam int ISR_HOST_WR = 1;
  localparam int ISR_EXT = 2;
  localparam logic [2:0] IMR_RST = 3'h0;
  localparam int RESET_DELAY_CLKS = 10;
  localparam int RST_CNT_W = 4;
  localparam int GAP_CLKS = 2;
  // host registers on the ahb-lite side, byte offsets
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h04;
  localparam logic [7:0] HREG_RDATA = 8'h08;
  localparam logic [7:0] HREG_STATUS = 8'h0c;
  localparam logic [7:0] HREG_IRQ_STAT = 8'h10;
  localparam logic [7:0] HREG_IRQ_MASK = 8'h14;
  localparam logic [7:0] HREG_CFG = 8'h18;
  localparam logic [7:0] HREG_SYS_RDATA = 8'h1c;
  localparam logic [7:0] HREG_SYS_WDATA = 8'h20;
  localparam logic [7:0] HREG_SYS_ADDR = 8'h24;
  localparam int CTRL_MEM_BIT = 0;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CFG_GRANT_BIT = 0;
  localparam int CFG_STYLE_BIT = 1;
  localparam int CFG_HWRST_BIT = 2;
  localparam int CFG_WAIT_LSB = 8;
  localparam int WAIT_W = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0001;
  localparam int HIRQ_W = 3;
  localparam int HIRQ_OP_DONE = 0;
  localparam int HIRQ_DEV_INT = 1;
  localparam int HIRQ_MST_DONE = 2;
endpackage

// >>> common/nsbp_if.sv
// pin-level link between the network controller and its host/memory bus.
// the shared data bus is resolved here from both ends' output enables.
`timescale 1ns/1ns
`default_nettype none
interface nsbp_if;
  import nsbp_pkg::*;
  logic hw_reset_n;
  logic bus_style_select;
  logic register_select_n;
  logic shared_memory_request_n;
  logic slave_address_latch_strobe;
  logic [RA_W-1:0] register_address_lines;
  logic slave_direction;
  logic slave_memory_acknowledge_n;
  logic device_interrupt;
  logic bus_hold_request;
  logic bus_grant_in;
  logic bus_grant_confirm_out_n;
  logic bus_grant_confirm_oe;
  logic master_address_valid_strobe_n;
  logic master_direction;
  logic [ADDR_W-1:0] master_address;
  logic master_ready_in;
  logic [DATA_W-1:0] dev_data_o;
  logic dev_data_oe;
  logic [DATA_W-1:0] host_data_o;
  logic host_data_oe;
  logic [DATA_W-1:0] data;
  // device wins a clash; undriven bus reads as zero
  assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : '0);
  modport dev (
    input hw_reset_n, bus_style_select, register_select_n, shared_memory_request_n,
    input slave_address_latch_strobe, register_address_lines, slave_direction,
    input bus_grant_in, master_ready_in, data,
    output slave_memory_acknowledge_n, device_interrupt, bus_hold_request,
    output bus_grant_confirm_out_n, bus_grant_confirm_oe, master_address_valid_strobe_n,
    output master_direction, master_address, dev_data_o, dev_data_oe
  );
  modport hst (
    output hw_reset_n, bus_style_select, register_select_n, shared_memory_request_n,
    output slave_address_latch_strobe, register_address_lines, slave_direction,
    output bus_grant_in, master_ready_in, host_data_o, host_data_oe,
    input slave_memory_acknowledge_n, device_interrupt, bus_hold_request,
    input bus_grant_confirm_out_n, bus_grant_confirm_oe, master_address_valid_strobe_n,
    input master_direction, master_address, data
  );
endinterface
`default_nettype wire

// >>> core/nsbp_sync.sv
// two-flop level synchroniser.
// assumes d is a level that stays put for at least two clocks.
`timescale 1ns/1ns
`default_nettype none
module nsbp_sync
#(
  parameter logic INIT = 1'b0
)
(
  input wire logic clk, // sampling clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);
  logic meta_r;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> core/nsbp_dev.sv
// device end of the shared-memory bus port: register slave, shared buffer ram
// with arbiter, one-word master engine on the system bus, interrupt output.
// assumes the host end keeps its select spacing and runs on the same clock.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module nsbp_dev
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // power-on reset, active low
  nsbp_if.dev bus, // pins toward host and system bus
  input wire logic ext_event, // one-cycle event from the core
  output logic dma_busy // master engine not idle
);
  import nsbp_pkg::*;
  typedef enum logic [2:0] {M_IDLE, M_FETCH, M_REQ, M_ADDR, M_DATA, M_REL} nsbp_mst_t;
  nsbp_mst_t mst_r;
  logic [DATA_W-1:0] ram [RAM_WORDS];
  logic [RST_CNT_W-1:0] rst_cnt_r;
  logic [RA_W-1:0] ra_r, loc_r;
  logic [DATA_W-1:0] rdat_r, sys_addr_r, xfer_r;
  logic [ISR_W-1:0] isr_r, imr_r, isr_set, isr_clr;
  logic [ADDR_W-1:0] maddr_r;
  logic soft_rst, ack_r, synchronous_bus_select_r, wdir_r, hold_r, ads_n_r, mdir_r, gcf_n_r, irq_r;
  logic cs_act, mq_act, reg_go, reg_wr, host_mem_go, dev_ram_wr, dev_ram_use, start;
  logic rdy_async, rdy_s, cyc_end, own;

  // pin decode; both selects never low together on a legal host
  assign cs_act = !bus.register_select_n;
  assign mq_act = !bus.shared_memory_request_n;
  assign reg_go = cs_act && !ack_r && !soft_rst;
  assign reg_wr = reg_go && bus.slave_direction;
  assign start = reg_wr && (ra_r == DREG_CMD) && bus.data[CMD_START_BIT] && (mst_r == M_IDLE);

  // device ram traffic always wins; the host waits one clock at most
  assign dev_ram_use = (mst_r == M_FETCH) || dev_ram_wr;
  assign host_mem_go = mq_act && !ack_r && !dev_ram_use && !soft_rst;

  // ready input: direct when the bus is synchronous, else synchronised
  nsbp_sync #(.INIT(1'b1)) u_rdy_sync (.clk(hclk), .rst_n(hresetn), .d(bus.master_ready_in), .q(rdy_async));
  assign rdy_s = synchronous_bus_select_r ? bus.master_ready_in : rdy_async;
  assign cyc_end = (mst_r == M_DATA) && !rdy_s;
  assign dev_ram_wr = cyc_end && !mdir_r;
  assign own = (mst_r == M_ADDR) || (mst_r == M_DATA);

  // reset pin must stay low a fixed number of clocks before it takes effect
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rst_cnt_r <= '0;
    else if (bus.hw_reset_n)
      rst_cnt_r <= '0;
    else if (!soft_rst)
      rst_cnt_r <= rst_cnt_r + 1'b1;
  end
  assign soft_rst = (rst_cnt_r == RST_CNT_W'(RESET_DELAY_CLKS));

  // register address latch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ra_r <= '0;
    else if (bus.slave_address_latch_strobe)
      ra_r <= bus.register_address_lines;
  end

  // acknowledge: once per access, dropped when the host lets go
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ack_r <= 1'b0;
    else if (soft_rst || (!cs_act && !mq_act))
      ack_r <= 1'b0;
    else if (reg_go || host_mem_go)
      ack_r <= 1'b1;
  end
  assign bus.slave_memory_acknowledge_n = !ack_r;

  // read data captured together with the acknowledge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdat_r <= '0;
    else if (host_mem_go)
      rdat_r <= ram[ra_r];
    else if (reg_go)
    begin
      case (ra_r)
        DREG_CMD: rdat_r <= DATA_W'({wdir_r, dma_busy});
        DREG_SYS_ADDR: rdat_r <= sys_addr_r;
        DREG_LOCAL: rdat_r <= DATA_W'(loc_r);
        DREG_ISR: rdat_r <= DATA_W'(isr_r);
        DREG_IMR: rdat_r <= DATA_W'(imr_r);
        DREG_DCR: rdat_r <= DATA_W'(synchronous_bus_select_r);
        DREG_XFER: rdat_r <= xfer_r;
        DREG_STATUS: rdat_r <= DATA_W'({own, hold_r, bus.bus_grant_in});
        default: rdat_r <= '0;
      endcase
    end
  end

  // shared buffer ram; contents survive the pin reset
  always_ff @(posedge hclk)
  begin
    if (dev_ram_wr)
      ram[loc_r] <= bus.data;
    else if (host_mem_go && bus.slave_direction)
      ram[ra_r] <= bus.data;
  end

  // software-written configuration
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sys_addr_r <= '0;
      loc_r <= '0;
      imr_r <= IMR_RST;
      synchronous_bus_select_r <= DCR_SYNCHRONOUS_BUS_SELECT_RST;
      wdir_r <= 1'b0;
    end
    else if (soft_rst)
    begin
      sys_addr_r <= '0;
      loc_r <= '0;
      imr_r <= IMR_RST;
      synchronous_bus_select_r <= DCR_SYNCHRONOUS_BUS_SELECT_RST;
      wdir_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (ra_r)
        DREG_CMD: wdir_r <= bus.data[CMD_WRITE_BIT];
        DREG_SYS_ADDR: sys_addr_r <= bus.data;
        DREG_LOCAL: loc_r <= bus.data[RA_W-1:0];
        DREG_IMR: imr_r <= bus.data[ISR_W-1:0];
        DREG_DCR: synchronous_bus_select_r <= bus.data[DCR_SYNCHRONOUS_BUS_SELECT_BIT];
        default: ;
      endcase
    end
  end

  // interrupt status: write one to clear, a new event wins over the clear
  assign isr_set = {ext_event, host_mem_go && bus.slave_direction, cyc_end};
  assign isr_clr = (reg_wr && ra_r == DREG_ISR) ? bus.data[ISR_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      isr_r <= '0;
    else
      isr_r <= soft_rst ? '0 : ((isr_r & ~isr_clr) | isr_set);
  end

  // interrupt level, one clock behind the status bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(isr_r & imr_r);
  end
  assign bus.device_interrupt = irq_r;

  // master engine: fetch (writes only), request, address strobe, wait, release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mst_r <= M_IDLE;
    else if (soft_rst)
      mst_r <= M_IDLE;
    else
    begin
      case (mst_r)
        M_IDLE:
          if (start)
            mst_r <= bus.data[CMD_WRITE_BIT] ? M_FETCH : M_REQ;
        M_FETCH: mst_r <= M_REQ;
        M_REQ:
          if (bus.bus_grant_in)
            mst_r <= M_ADDR;
        M_ADDR: mst_r <= M_DATA;
        M_DATA:
          if (cyc_end)
            mst_r <= M_REL;
        M_REL:
          if (!bus.bus_grant_in)
            mst_r <= M_IDLE;
        default: mst_r <= M_IDLE;
      endcase
    end
  end
  assign dma_busy = (mst_r != M_IDLE);

  // transfer word: ram word to send, or word returned by memory
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      xfer_r <= '0;
    else if (mst_r == M_FETCH)
      xfer_r <= ram[loc_r];
    else if (dev_ram_wr)
      xfer_r <= bus.data;
  end

  // hold request from the start order until the cycle has ended
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_r <= 1'b0;
    else if (soft_rst || cyc_end)
      hold_r <= 1'b0;
    else if (start)
      hold_r <= 1'b1;
  end
  assign bus.bus_hold_request = hold_r;

  // address strobe low for one clock; address and direction set with its fall
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ads_n_r <= 1'b1;
      maddr_r <= '0;
      mdir_r <= 1'b0;
    end
    else if (mst_r == M_REQ && bus.bus_grant_in && !soft_rst)
    begin
      ads_n_r <= 1'b0;
      maddr_r <= sys_addr_r;
      mdir_r <= wdir_r;
    end
    else
      ads_n_r <= 1'b1;
  end
  assign bus.master_address_valid_strobe_n = ads_n_r;
  assign bus.master_address = maddr_r;
  assign bus.master_direction = mdir_r;

  // grant confirm low while owning; the pin is released in style zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gcf_n_r <= 1'b1;
    else
      gcf_n_r <= !(mst_r == M_REQ && bus.bus_grant_in) && !(mst_r == M_ADDR) && !(mst_r == M_DATA && !cyc_end);
  end
  assign bus.bus_grant_confirm_out_n = gcf_n_r;
  assign bus.bus_grant_confirm_oe = bus.bus_style_select;

  // data bus: master write word while owning, else slave read answer
  assign bus.dev_data_oe = (own && mdir_r) || (ack_r && (cs_act || mq_act) && !bus.slave_direction);
  assign bus.dev_data_o = (own && mdir_r) ? xfer_r : rdat_r;
endmodule
`default_nettype wire

// >>> core/nsbp_host.sv
// host end: ahb-lite register slave that runs register and shared-memory
// accesses on the device pins, grants the bus and answers master cycles.
// assumes one bus clock shared with the device and with the ahb master.
`timescale 1ns/1ns
`default_nettype none
module nsbp_host
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  output logic irq, // unmasked host status pending
  nsbp_if.hst bus // pins toward the device
);
  import nsbp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_LATCH, H_SEL, H_GAP} nsbp_hst_t;

  nsbp_hst_t st_r;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic [31:0] ctrl_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [31:0] cfg_r;
  logic [31:0] sys_rdata_r;
  logic [DATA_W-1:0] sys_wdata_r;
  logic [ADDR_W-1:0] sys_addr_r;
  logic [HIRQ_W-1:0] hirq_r;
  logic [HIRQ_W-1:0] hmask_r;
  logic [HIRQ_W-1:0] hirq_set;
  logic [HIRQ_W-1:0] hirq_clr;
  logic [1:0] gap_r;
  logic grant_r;
  logic ads_prev_r;
  logic dint_prev_r;
  logic resp_r;
  logic rdy_r;
  logic [WAIT_W-1:0] wcnt_r;
  logic ahb_take;
  logic go;
  logic op_done;
  logic mst_done;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ahb_take = hsel && hready && htrans[1];
  assign go = wr_pend_r && (waddr_r == HREG_CTRL) && (st_r == H_IDLE);
  assign op_done = (st_r == H_SEL) && !bus.slave_memory_acknowledge_n;
  assign mst_done = resp_r && !bus.bus_hold_request;

  // address phase captured; read data loaded for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      waddr_r <= '0;
      hrdata <= '0;
    end
    else
    begin
      wr_pend_r <= ahb_take && hwrite;
      waddr_r <= haddr[7:0];
      if (ahb_take && !hwrite)
      begin
        case (haddr[7:0])
          HREG_CTRL: hrdata <= ctrl_r;
          HREG_WDATA: hrdata <= wdata_r;
          HREG_RDATA: hrdata <= rdata_r;
          HREG_STATUS: hrdata <= {29'h0, bus.bus_hold_request, bus.device_interrupt, st_r != H_IDLE};
          HREG_IRQ_STAT: hrdata <= 32'(hirq_r);
          HREG_IRQ_MASK: hrdata <= 32'(hmask_r);
          HREG_CFG: hrdata <= cfg_r;
          HREG_SYS_RDATA: hrdata <= sys_rdata_r;
          HREG_SYS_WDATA: hrdata <= 32'(sys_wdata_r);
          HREG_SYS_ADDR: hrdata <= 32'(sys_addr_r);
          default: hrdata <= '0;
        endcase
      end
    end
  end

  // plain registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= '0;
      wdata_r <= '0;
      cfg_r <= CFG_RST;
      hmask_r <= '0;
      sys_rdata_r <= '0;
    end
    else if (wr_pend_r)
    begin
      case (waddr_r)
        HREG_CTRL: if (st_r == H_IDLE) ctrl_r <= hwdata;
        HREG_WDATA: wdata_r <= hwdata;
        HREG_IRQ_MASK: hmask_r <= hwdata[HIRQ_W-1:0];
        HREG_CFG: cfg_r <= hwdata;
        HREG_SYS_RDATA: sys_rdata_r <= hwdata;
        default: ;
      endcase
    end
  end

  // sticky status, write one to clear, set wins
  assign hirq_set = {mst_done, bus.device_interrupt && !dint_prev_r, op_done};
  assign hirq_clr = (wr_pend_r && waddr_r == HREG_IRQ_STAT) ? hwdata[HIRQ_W-1:0] : '0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hirq_r <= '0;
      dint_prev_r <= 1'b0;
    end
    else
    begin
      hirq_r <= (hirq_r & ~hirq_clr) | hirq_set;
      dint_prev_r <= bus.device_interrupt;
    end
  end
  assign irq = |(hirq_r & hmask_r);

  // access sequencer: latch address, select, wait acknowledge, spacing gap
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= H_IDLE;
      gap_r <= '0;
      rdata_r <= '0;
    end
    else
    begin
      case (st_r)
        H_IDLE:
          if (go)
            st_r <= H_LATCH;
        H_LATCH: st_r <= H_SEL;
        H_SEL:
          if (op_done)
          begin
            rdata_r <= 32'(bus.data);
            gap_r <= 2'(GAP_CLKS);
            st_r <= H_GAP;
          end
        H_GAP:
        begin
          gap_r <= gap_r - 1'b1;
          if (gap_r == 2'd1)
            st_r <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
  assign bus.slave_address_latch_strobe = (st_r == H_LATCH);
  assign bus.register_address_lines = ctrl_r[CTRL_ADDR_LSB +: RA_W];
  assign bus.register_select_n = !(st_r == H_SEL && !ctrl_r[CTRL_MEM_BIT]);
  assign bus.shared_memory_request_n = !(st_r == H_SEL && ctrl_r[CTRL_MEM_BIT]);
  assign bus.slave_direction = ctrl_r[CTRL_WR_BIT];
  assign bus.hw_reset_n = !cfg_r[CFG_HWRST_BIT];
  assign bus.bus_style_select = cfg_r[CFG_STYLE_BIT];

  // grant follows the hold request while granting is enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      grant_r <= 1'b0;
    else
      grant_r <= bus.bus_hold_request && cfg_r[CFG_GRANT_BIT];
  end
  assign bus.bus_grant_in = grant_r;

  // memory responder: waits after the strobe's rising edge, then ready low
  // held until hold drops, so a synchronised ready is never missed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ads_prev_r <= 1'b1;
      resp_r <= 1'b0;
      rdy_r <= 1'b1;
      wcnt_r <= '0;
      sys_addr_r <= '0;
      sys_wdata_r <= '0;
    end
    else
    begin
      ads_prev_r <= bus.master_address_valid_strobe_n;
      if (!ads_prev_r && bus.master_address_valid_strobe_n && grant_r)
      begin
        resp_r <= 1'b1;
        sys_addr_r <= bus.master_address;
        wcnt_r <= cfg_r[CFG_WAIT_LSB +: WAIT_W];
      end
      else if (mst_done)
      begin
        resp_r <= 1'b0;
        rdy_r <= 1'b1;
      end
      else if (resp_r && rdy_r)
      begin
        if (wcnt_r == '0)
        begin
          rdy_r <= 1'b0;
          if (bus.master_direction)
            sys_wdata_r <= bus.data;
        end
        else
          wcnt_r <= wcnt_r - 1'b1;
      end
    end
  end
  assign bus.master_ready_in = rdy_r;

  // data bus: read answer to the device, or slave write data
  assign bus.host_data_oe = (resp_r && !bus.master_direction) || (st_r == H_SEL && ctrl_r[CTRL_WR_BIT]);
  assign bus.host_data_o = resp_r ? sys_rdata_r[DATA_W-1:0] : wdata_r[DATA_W-1:0];
endmodule
`default_nettype wire

// >>> sim/nsbp_sva.sv
// checker on the pins joining host end and device end.
// assumes one clock domain; inputs are the link's own signals.
`timescale 1ns/1ns
`default_nettype none
module nsbp_sva
(
  input wire logic hclk, // bus clock
  input wire logic hresetn, // reset, low
  input wire logic register_select_n, // reg select
  input wire logic shared_memory_request_n, // ram request
  input wire logic slave_memory_acknowledge_n, // ack
  input wire logic bus_hold_request, // hold
  input wire logic bus_grant_in, // grant
  input wire logic master_address_valid_strobe_n, // strobe
  input wire logic [nsbp_pkg::ADDR_W-1:0] master_address, // address
  input wire logic master_ready_in // low ends cycle
);
  import nsbp_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // slave side: selects kept apart, ack follows its select
  property p_apart; register_select_n || shared_memory_request_n; endproperty
  a_apart: assert property (p_apart) else $error("selects overlap");
  property p_gap; $rose(register_select_n) || $rose(shared_memory_request_n)
    |-> (register_select_n && shared_memory_request_n)[*2]; endproperty
  a_gap: assert property (p_gap) else $error("select gap short");
  property p_ack; $fell(slave_memory_acknowledge_n)
    |-> !$past(register_select_n) || !$past(shared_memory_request_n); endproperty
  a_ack: assert property (p_ack) else $error("ack without select");
  property p_ack_off; register_select_n && shared_memory_request_n |=> slave_memory_acknowledge_n; endproperty
  a_ack_off: assert property (p_ack_off) else $error("ack stuck");
  // master side: cycles only while owning the bus
  property p_grant; $fell(master_address_valid_strobe_n) |-> $past(bus_grant_in); endproperty
  a_grant: assert property (p_grant) else $error("strobe without grant");
  property p_own; !master_address_valid_strobe_n |-> bus_hold_request && bus_grant_in; endproperty
  a_own: assert property (p_own) else $error("strobe without hold");
  property p_end; $fell(bus_hold_request) |-> !$past(master_ready_in); endproperty
  a_end: assert property (p_end) else $error("hold dropped early");
  property p_addr; $rose(master_address_valid_strobe_n) |-> $stable(master_address); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
endmodule
`default_nettype wire

// >>> sim/tb_nic_shared_memory_bus_port.sv
// bench: ahb master on the host end, device end on the pins, ram model.
// assumes a 25 mhz clock and zero-wait ahb answers that are still waited for.
`timescale 1ns/1ns
`default_nettype none
module tb_nic_shared_memory_bus_port;
  import nsbp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, irq, ext_event, dma_busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r, v;
  int num_errors, cmp_count, seed, s, k, ix;
  int ram [RAM_WORDS];
  nsbp_if u_nsbp_if();
  nsbp_dev u_nsbp_dev (.hclk(hclk), .hresetn(hresetn), .bus(u_nsbp_if.dev), .ext_event(ext_event),
    .dma_busy(dma_busy));
  nsbp_host u_nsbp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .bus(u_nsbp_if.hst));
  nsbp_sva u_nsbp_sva (.hclk(hclk), .hresetn(hresetn), .register_select_n(u_nsbp_if.register_select_n),
    .shared_memory_request_n(u_nsbp_if.shared_memory_request_n), .bus_grant_in(u_nsbp_if.bus_grant_in),
    .slave_memory_acknowledge_n(u_nsbp_if.slave_memory_acknowledge_n), .master_ready_in(u_nsbp_if.master_ready_in),
    .bus_hold_request(u_nsbp_if.bus_hold_request), .master_address(u_nsbp_if.master_address),
    .master_address_valid_strobe_n(u_nsbp_if.master_address_valid_strobe_n));
  initial
  begin
    hclk = 0;
    forever #20 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one single ahb transfer; read data lands in r
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // bounded wait on a sticky host status bit, then clear it
  task automatic pollst(input int b);
    int i;
    i = 0;
    do
    begin
      ahb(0, HREG_IRQ_STAT, 0);
      i++;
    end
    while (r[b] !== 1'b1 && i < 99);
    chk(r[b], 1);
    ahb(1, HREG_IRQ_STAT, 1 << b);
  endtask
  // one register or ram access on the device pins
  task automatic dev(input logic w, m, input logic [5:0] a, input logic [15:0] d);
    ahb(1, HREG_WDATA, d);
    ahb(1, HREG_CTRL, {a, 6'h0, w, m});
    pollst(0);
    ahb(0, HREG_RDATA, 0);
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    seed = 32'hefd4a017;
    {hresetn, hsel, hwrite, ext_event} = 4'h4;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    // ram words at both ends and one random, back to back
    for (k = 0; k < 3; k++)
    begin
      v = $random(seed);
      ix = (k == 2) ? v[21:16] : k * 63;
      ram[ix] = v[15:0];
      dev(1, 1, ix[5:0], v[15:0]);
      dev(0, 1, ix[5:0], 0);
      chk(r, ram[ix]);
    end
    dev(1, 0, DREG_IMR, 1);
    dev(0, 0, DREG_IMR, 0);
    chk(r, 1);
    // master read then write, async then sync ready, random waits
    for (s = 0; s < 2; s++)
    begin
      v = $random(seed);
      ahb(1, HREG_CFG, {v[18:16], 6'h0, s[0], 1'b1});
      dev(1, 0, DREG_DCR, s);
      chk(u_nsbp_if.bus_grant_confirm_oe, s[0]);
      ahb(1, HREG_SYS_RDATA, v[15:0]);
      dev(1, 0, DREG_LOCAL, v[29:24]);
      dev(1, 0, DREG_SYS_ADDR, v[31:16]);
      dev(1, 0, DREG_CMD, 1);
      pollst(2);
      ram[v[29:24]] = v[15:0];
      ahb(0, HREG_SYS_ADDR, 0);
      chk(r, v[31:16]);
      dev(0, 1, v[29:24], 0);
      chk(r, ram[v[29:24]]);
      dev(1, 0, DREG_CMD, 3);
      pollst(2);
      ahb(0, HREG_SYS_WDATA, 0);
      chk(r, ram[v[29:24]]);
      chk(dma_busy, 0);
    end
    // device interrupt raised, masked; host irq raised, cleared
    ahb(0, HREG_STATUS, 0);
    chk(r[1], 1);
    ahb(1, HREG_IRQ_MASK, 2);
    @(posedge hclk);
    chk(irq, 1);
    dev(1, 0, DREG_IMR, 4);
    ahb(0, HREG_STATUS, 0);
    chk(r[1], 0);
    ahb(1, HREG_IRQ_STAT, 7);
    @(posedge hclk);
    chk(irq, 0);
    // core event with its source enabled raises the pin; write one clears it
    ext_event <= 1;
    @(posedge hclk);
    ext_event <= 0;
    repeat (2) @(posedge hclk);
    ahb(0, HREG_STATUS, 0);
    chk(r[1], 1);
    dev(1, 0, DREG_ISR, 4);
    ahb(0, HREG_STATUS, 0);
    chk(r[1], 0);
    // device reset pin: registers cleared, ram kept
    ahb(1, HREG_CFG, 5);
    repeat (12) @(posedge hclk);
    ahb(1, HREG_CFG, 1);
    dev(0, 0, DREG_IMR, 0);
    chk(r, 0);
    dev(0, 1, 0, 0);
    chk(r, ram[0]);
    end_of_test();
  end
endmodule
`default_nettype wire
